// ### design/cmb_pkg.sv
// Package for the CAN message buffer block: word offsets, field positions, frame carriers.
// Assumes a 16-bit object memory word per buffer register on a 32-bit Wishbone bus.
package cmb_pkg;
    // ****************************************
    // Register word indices and the status word index
    // ****************************************
    localparam logic [2:0] CMB_IDX_CTRL  = 3'h0;
    localparam logic [2:0] CMB_IDX_BUFFER_TIME_STAMP  = 3'h1;
    localparam logic [2:0] CMB_IDX_PAYLOAD_WORD_3 = 3'h2;
    localparam logic [2:0] CMB_IDX_PAYLOAD_WORD_2 = 3'h3;
    localparam logic [2:0] CMB_IDX_PAYLOAD_WORD_1 = 3'h4;
    localparam logic [2:0] CMB_IDX_PAYLOAD_WORD_0 = 3'h5;
    localparam logic [2:0] CMB_IDX_IDLO  = 3'h6;
    localparam logic [2:0] CMB_IDX_IDHI  = 3'h7;
    localparam logic [3:0] CMB_ADDR_STAT = 4'h8;
    localparam int         CMB_ADDR_W    = 6;
    localparam int         CMB_WORDS     = 8;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CMB_IDHI_STDID_LSB = 5;
    localparam int CMB_IDHI_RTR_BIT   = 4;
    localparam int CMB_IDHI_IDE_BIT   = 3;
    localparam int CMB_IDLO_RTR_BIT   = 0;
    localparam int CMB_CTRL_DLC_LSB   = 12;
    localparam int CMB_CTRL_DLC_MSB   = 15;
    localparam int CMB_IDHI_STDID_MSB = 15;
    localparam int CMB_IDHI_EXTID_MSB = 2;
    localparam int CMB_IDLO_EXTID_MSB = 15;
    localparam int CMB_IDLO_EXTID_LSB = 1;
    localparam int CMB_ADR_IDX_MSB    = 5;
    localparam int CMB_ADR_IDX_LSB    = 2;
    localparam int CMB_EXT_ID_W       = 29;
    localparam int CMB_STAT_BUSY_BIT  = 0;
    localparam int CMB_STAT_TX_BIT    = 1;
    localparam int CMB_STAT_RX_BIT    = 2;
    localparam logic [3:0] CMB_MAX_BYTES = 4'h8;
    localparam logic [15:0] CMB_RESET_WORD = 16'h0000;
    // ****************************************
    // Frame carrier between buffer and protocol engine
    // ****************************************
    typedef struct packed {
        logic        ide;
        logic        rtr;
        logic        srr;
        logic [28:0] id;
        logic [3:0]  dlc;
    } cmb_hdr_t;
endpackage

// ### design/cmb_buffer.sv
// One CAN message buffer: eight 16-bit words, packed and unpacked for the protocol engine.
// Assumes a classic Wishbone master on the register side and a byte-wise engine port.
//
// Contract
// - A standard frame is stored with the extension bit of the high identifier word cleared.
// - Standard frames ignore high word bits 2:0 and the whole low identifier word.
// - Standard identifier sits in high word bits 15:5 with remote and extension bits below.
// - Payload bytes pack two per data word, byte one in the upper half of the first word.
// - On transmit, unused payload byte positions are disregarded.
// - On receive, unused payload byte positions may be overwritten with invalid values.
// - A set extension bit makes the buffer carry extended frames with the extended layout.
// - On extended receive the substitute bit is stored as sampled on the bus.
// - Extended id 28:18 in high 15:5, 17:15 in high 2:0, 14:0 in low 15:1, remote in low 0.
// - The remote bit is zero for a data frame and one for a remote frame both ways.
// - The extension bit is zero for an eleven-bit standard frame and one for extended.
// - Transmitting a remote frame ignores all four data words.
// - Receiving a remote frame may overwrite all four data words with invalid values.
// - A length code of eight or above is treated as eight bytes both ways.
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module cmb_buffer #(
    parameter int ID_W = 29
) (
    // Clock and reset
    input  wire  logic                  clk_i,
    input  wire  logic                  rst_i,
    // Wishbone slave
    input  wire  logic                  cyc_i,
    input  wire  logic                  stb_i,
    input  wire  logic                  we_i,
    input  wire  logic [cmb_pkg::CMB_ADDR_W-1:0] adr_i,
    input  wire  logic [3:0]            sel_i,
    input  wire  logic [31:0]           dat_i,
    output logic [31:0]                 dat_o,
    output logic                        ack_o,
    // Engine transmit side
    input  wire  logic                  tx_load_i,
    output cmb_pkg::cmb_hdr_t           tx_hdr_o,
    input  wire  logic                  tx_byte_rd_i,
    output logic [7:0]                  tx_byte_o,
    output logic                        tx_last_o,
    // Engine receive side
    input  wire  logic                  rx_start_i,
    input  wire  cmb_pkg::cmb_hdr_t     rx_hdr_i,
    input  wire  logic                  rx_byte_vld_i,
    input  wire  logic [7:0]            rx_byte_i,
    input  wire  logic                  rx_done_i,
    // Buffer status
    output logic                        busy_o
);
    // ****************************************
    // State
    // ****************************************
    typedef enum logic [1:0] {CMB_IDLE, CMB_TX, CMB_RX} cmb_mode_t;
    typedef struct packed {
        logic [cmb_pkg::CMB_WORDS-1:0][15:0] mem;
        cmb_mode_t         mode;
        logic [3:0]        cnt;
        logic [3:0]        len;
        logic [31:0]       rdat;
        logic              ack;
        cmb_pkg::cmb_hdr_t thdr;
        logic [7:0]        tbyte;
        logic              tlast;
        logic              busy;
    } cmb_state_t;

    cmb_state_t s_q;
    cmb_state_t s_d;

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (ID_W != cmb_pkg::CMB_EXT_ID_W)
    begin : g_bad_id_w
        $error("cmb_buffer: ID_W must match the extended identifier width");
    end
    if (cmb_pkg::CMB_ADDR_W <= cmb_pkg::CMB_ADR_IDX_MSB)
    begin : g_bad_addr_w
        $error("cmb_buffer: address too narrow for the word index");
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [3:0] cmb_clip(input logic [3:0] dlc);
        if (dlc >= cmb_pkg::CMB_MAX_BYTES)
        begin
            return cmb_pkg::CMB_MAX_BYTES;
        end
        return dlc;
    endfunction

    // Byte n of the payload: word PAYLOAD_WORD_0 - n/2, upper half first
    function automatic logic [7:0] cmb_get_byte(
        input logic [cmb_pkg::CMB_WORDS-1:0][15:0] m, input logic [2:0] n);
        logic [15:0] w;
        w = m[cmb_pkg::CMB_IDX_PAYLOAD_WORD_0 - {1'b0, n[2:1]}];
        return n[0] ? w[7:0] : w[15:8];
    endfunction

    // ****************************************
    // Field slices
    // ****************************************
    localparam int SID_H = cmb_pkg::CMB_IDHI_STDID_MSB;
    localparam int SID_L = cmb_pkg::CMB_IDHI_STDID_LSB;
    localparam int XHI_H = cmb_pkg::CMB_IDHI_EXTID_MSB;
    localparam int XLO_H = cmb_pkg::CMB_IDLO_EXTID_MSB;
    localparam int XLO_L = cmb_pkg::CMB_IDLO_EXTID_LSB;
    localparam int DLC_H = cmb_pkg::CMB_CTRL_DLC_MSB;
    localparam int DLC_L = cmb_pkg::CMB_CTRL_DLC_LSB;
    localparam int IDX_H = cmb_pkg::CMB_ADR_IDX_MSB;
    localparam int IDX_L = cmb_pkg::CMB_ADR_IDX_LSB;
    localparam int STD_W = SID_H - SID_L + 1;

    logic            bus_req;
    logic            bus_wr;
    logic [3:0]      word_nr;
    logic [2:0]      widx;
    logic            wsel;
    logic            ssel;
    logic [15:0]     hi_w;
    logic [15:0]     lo_w;
    logic [3:0]      dlc_w;
    logic            tx_ext;
    logic            tx_rtr;
    logic [ID_W-1:0] tx_id;
    logic [3:0]      tx_len;
    logic [15:0]     rx_hi_w;
    logic [15:0]     rx_lo_w;
    logic [3:0]      rx_len;
    logic [31:0]     stat_w;

    // Request taken while ack is low; a write lands at the edge that sees ack
    assign bus_req = cyc_i & stb_i & ~s_q.ack;
    assign bus_wr  = cyc_i & stb_i & we_i & s_q.ack;
    assign word_nr = adr_i[IDX_H:IDX_L];
    assign wsel    = (word_nr < 4'(cmb_pkg::CMB_WORDS));
    assign ssel    = (word_nr == cmb_pkg::CMB_ADDR_STAT);
    assign widx    = word_nr[2:0];
    assign hi_w    = s_q.mem[cmb_pkg::CMB_IDX_IDHI];
    assign lo_w    = s_q.mem[cmb_pkg::CMB_IDX_IDLO];
    assign dlc_w   = s_q.mem[cmb_pkg::CMB_IDX_CTRL][DLC_H:DLC_L];

    // ****************************************
    // Transmit header decode
    // ****************************************
    always_comb
    begin
        tx_ext = hi_w[cmb_pkg::CMB_IDHI_IDE_BIT];
        if (tx_ext)
        begin
            // Extended layout, identifier split over both words
            tx_id  = {hi_w[SID_H:SID_L], hi_w[XHI_H:0], lo_w[XLO_H:XLO_L]};
            tx_rtr = lo_w[cmb_pkg::CMB_IDLO_RTR_BIT];
        end
        else
        begin
            // Low word and bits below the extension bit unused
            tx_id  = {(ID_W - STD_W)'(0), hi_w[SID_H:SID_L]};
            tx_rtr = hi_w[cmb_pkg::CMB_IDHI_RTR_BIT];
        end
        // Remote frames send no payload
        if (tx_rtr)
        begin
            tx_len = 4'h0;
        end
        else
        begin
            tx_len = cmb_clip(dlc_w);
        end
    end

    // ****************************************
    // Receive header packing
    // ****************************************
    always_comb
    begin
        rx_hi_w = hi_w;
        rx_lo_w = lo_w;
        if (rx_hdr_i.ide)
        begin
            rx_hi_w = {rx_hdr_i.id[28:18], rx_hdr_i.srr, 1'b1,
                       rx_hdr_i.id[17:15]};
            rx_lo_w = {rx_hdr_i.id[14:0], rx_hdr_i.rtr};
        end
        else
        begin
            // Standard frame leaves the low identifier word as is
            rx_hi_w = {rx_hdr_i.id[STD_W-1:0], rx_hdr_i.rtr, 1'b0, 3'h0};
        end
        // Remote frames store no payload; data words keep stale values
        if (rx_hdr_i.rtr)
        begin
            rx_len = 4'h0;
        end
        else
        begin
            rx_len = cmb_clip(rx_hdr_i.dlc);
        end
    end

    // ****************************************
    // Read-only status word
    // ****************************************
    always_comb
    begin
        stat_w                             = 32'h00000000;
        stat_w[cmb_pkg::CMB_STAT_BUSY_BIT] = s_q.busy;
        stat_w[cmb_pkg::CMB_STAT_TX_BIT]   = (s_q.mode == CMB_TX);
        stat_w[cmb_pkg::CMB_STAT_RX_BIT]   = (s_q.mode == CMB_RX);
    end

    // ****************************************
    // Next state
    // ****************************************

    always_comb
    begin
        s_d       = s_q;
        s_d.ack   = bus_req;
        s_d.tlast = 1'b0;
        // ****************************************
        // Wishbone access, one wait state
        // ****************************************
        if (bus_wr && wsel)
        begin
            // Write lands at the edge that samples ack high
            if (sel_i[0])
            begin
                s_d.mem[widx][7:0] = dat_i[7:0];
            end
            if (sel_i[1])
            begin
                s_d.mem[widx][15:8] = dat_i[15:8];
            end
        end
        if (bus_req)
        begin
            if (wsel)
            begin
                s_d.rdat = {16'h0000, s_q.mem[widx]};
            end
            else if (ssel)
            begin
                s_d.rdat = stat_w;
            end
            else
            begin
                s_d.rdat = 32'h00000000;
            end
        end
        // ****************************************
        // Protocol engine side
        // ****************************************
        case (s_q.mode)
            CMB_IDLE:
            begin
                if (tx_load_i)
                begin
                    s_d.thdr.ide = tx_ext;
                    s_d.thdr.rtr = tx_rtr;
                    // Substitute bit always sent recessive on extended frames
                    s_d.thdr.srr = tx_ext;
                    s_d.thdr.id  = tx_id;
                    s_d.thdr.dlc = cmb_clip(dlc_w);
                    s_d.len      = tx_len;
                    s_d.cnt      = 4'h0;
                    s_d.tbyte    = cmb_get_byte(s_q.mem, 3'h0);
                    s_d.mode  = CMB_TX;
                end
                else if (rx_start_i)
                begin
                    s_d.cnt  = 4'h0;
                    s_d.mode = CMB_RX;
                    s_d.mem[cmb_pkg::CMB_IDX_IDHI] = rx_hi_w;
                    s_d.mem[cmb_pkg::CMB_IDX_IDLO] = rx_lo_w;
                    s_d.mem[cmb_pkg::CMB_IDX_CTRL][DLC_H:DLC_L] = rx_hdr_i.dlc;
                    s_d.len = rx_len;
                end
            end
            CMB_TX:
            begin
                if (s_q.len == 4'h0)
                begin
                    s_d.tlast = 1'b1;
                    s_d.mode  = CMB_IDLE;
                end
                else if (tx_byte_rd_i)
                begin
                    s_d.cnt   = s_q.cnt + 4'h1;
                    s_d.tbyte = cmb_get_byte(s_q.mem, s_q.cnt[2:0] + 3'h1);
                    if (s_q.cnt + 4'h1 == s_q.len)
                    begin
                        s_d.tlast = 1'b1;
                        s_d.mode  = CMB_IDLE;
                    end
                end
            end
            CMB_RX:
            begin
                if (rx_byte_vld_i && s_q.cnt < s_q.len)
                begin
                    if (s_q.cnt[0])
                    begin
                        s_d.mem[cmb_pkg::CMB_IDX_PAYLOAD_WORD_0 - {1'b0, s_q.cnt[2:1]}][7:0] =
                            rx_byte_i;
                    end
                    else
                    begin
                        // Low half left as is until its byte arrives
                        s_d.mem[cmb_pkg::CMB_IDX_PAYLOAD_WORD_0 - {1'b0, s_q.cnt[2:1]}][15:8] =
                            rx_byte_i;
                    end
                    s_d.cnt = s_q.cnt + 4'h1;
                end
                if (rx_done_i)
                begin
                    s_d.mode = CMB_IDLE;
                end
            end
            default:
            begin
                s_d.mode = CMB_IDLE;
            end
        endcase
        s_d.busy = (s_d.mode != CMB_IDLE);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs, all straight from the state register
    // ****************************************
    assign dat_o     = s_q.rdat;
    assign ack_o     = s_q.ack;
    assign tx_hdr_o  = s_q.thdr;
    assign tx_byte_o = s_q.tbyte;
    assign tx_last_o = s_q.tlast;
    assign busy_o    = s_q.busy;
endmodule // cmb_buffer
`default_nettype wire

// ### testbench/cmb_chk.sv
// Port assertions for the CAN message buffer.
// Bound to every cmb_buffer instance; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module cmb_chk (
    // Clock, reset and bus
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              cyc_i,
    input wire logic              stb_i,
    input wire logic [31:0]       dat_o,
    input wire logic              ack_o,
    // Engine side
    input wire logic              tx_load_i,
    input wire cmb_pkg::cmb_hdr_t tx_hdr_o,
    input wire logic              tx_last_o,
    input wire logic              rx_start_i,
    input wire logic              rx_done_i,
    input wire logic              busy_o
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus answer late");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_dat_high: assert property (ack_o |-> dat_o[31:16] == 16'h0)
        else $error("upper read bits set");
    a_srr_ide: assert property ($past(tx_load_i) && $rose(busy_o)
        |-> tx_hdr_o.srr == tx_hdr_o.ide) else $error("substitute bit wrong");
    a_empty_end: assert property ($past(tx_load_i) && $rose(busy_o) && tx_hdr_o.rtr
        |-> ##[0:2] tx_last_o) else $error("remote frame sent bytes");
    a_tx_busy: assert property (tx_load_i && !busy_o && !rx_start_i |=> busy_o)
        else $error("transmit not started");
    a_last_once: assert property (tx_last_o |=> !tx_last_o) else $error("last held");
    a_last_idle: assert property (tx_last_o |-> ##[0:1] !busy_o)
        else $error("busy after last byte");
    a_rx_busy: assert property (rx_start_i && !busy_o |=> busy_o)
        else $error("receive not started");
    a_rx_idle: assert property (rx_done_i |=> !busy_o) else $error("busy after frame end");
    c_remote: cover property ($rose(busy_o) && tx_hdr_o.rtr);
    c_rx_end: cover property (rx_done_i);
    c_bus: cover property (ack_o);
endmodule // cmb_chk
bind cmb_buffer cmb_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o, .tx_load_i,
    .tx_hdr_o, .tx_last_o, .rx_start_i, .rx_done_i, .busy_o);
`default_nettype wire

// ### testbench/cmb_eng.sv
// Protocol engine model for the CAN message buffer.
// Driven through its tasks by the bench.
`timescale 1ns/10ps
`default_nettype none
module cmb_eng (
    input  wire logic              clk_i,
    // Transmit side
    output var  logic              tx_load_o,
    output var  logic              tx_rd_o,
    input  wire cmb_pkg::cmb_hdr_t tx_hdr_i,
    input  wire logic [7:0]        tx_byte_i,
    input  wire logic              tx_last_i,
    // Receive side
    output var  logic              rx_start_o,
    output var  cmb_pkg::cmb_hdr_t rx_hdr_o,
    output var  logic              rx_vld_o,
    output var  logic [7:0]        rx_byte_o,
    output var  logic              rx_done_o
);
    // ****************
    // Frame tasks
    // ****************
    logic              seen_q = 1'b0;
    cmb_pkg::cmb_hdr_t got_hdr;
    logic [7:0]        got [0:8];
    int                got_n;
    initial
    begin
        {tx_load_o, tx_rd_o, rx_start_o, rx_vld_o, rx_done_o} = 5'h00;
        rx_hdr_o = '0;
        rx_byte_o = 8'h00;
    end
    always @(posedge clk_i) seen_q <= tx_load_o ? 1'b0 : (seen_q | tx_last_i);
    task automatic tx_frame();
        @(posedge clk_i) tx_load_o <= 1'b1;
        @(posedge clk_i) tx_load_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        got_hdr = tx_hdr_i;
        got_n = 0;
        while (!seen_q && got_n < 9)
        begin
            got[got_n] = tx_byte_i;
            got_n++;
            tx_rd_o <= 1'b1;
            @(posedge clk_i) tx_rd_o <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask
    task automatic rx_frame(input cmb_pkg::cmb_hdr_t h, input logic [63:0] b, input int n);
        @(posedge clk_i) rx_start_o <= 1'b1;
        rx_hdr_o <= h;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i) rx_start_o <= 1'b0;
            rx_hdr_o <= ~h;
            rx_vld_o <= 1'b1;
            rx_byte_o <= b[63-8*i -: 8];
        end
        @(posedge clk_i) rx_start_o <= 1'b0;
        {rx_vld_o, rx_done_o} <= 2'b01;
        rx_hdr_o <= ~h;
        rx_byte_o <= ~rx_byte_o;
        @(posedge clk_i) rx_done_o <= 1'b0;
    endtask
endmodule // cmb_eng
`default_nettype wire

// ### testbench/test_can_message_buffer_layout.sv
// Self-checking bench for the CAN message buffer.
// Uses the engine model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module test_can_message_buffer_layout;
    // ****************
    // Bench
    // ****************
    localparam logic [28:0] IDX = 29'h15a3c3e1;
    localparam logic [28:0] IDR = 29'h0c3a5e17;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [5:0]  adr_i = 6'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, r;
    logic ack_o, tx_load_i, tx_byte_rd_i, tx_last_o, rx_start_i, rx_byte_vld_i, rx_done_i, busy_o;
    logic [7:0]  tx_byte_o, rx_byte_i;
    cmb_pkg::cmb_hdr_t tx_hdr_o, rx_hdr_i;
    int miscompares = 0, comparisons = 0, cycles = 0;
    cmb_buffer DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .tx_load_i, .tx_hdr_o, .tx_byte_rd_i, .tx_byte_o, .tx_last_o, .rx_start_i, .rx_hdr_i,
        .rx_byte_vld_i, .rx_byte_i, .rx_done_i, .busy_o);
    cmb_eng eng (.clk_i, .tx_load_o(tx_load_i), .tx_rd_o(tx_byte_rd_i), .tx_hdr_i(tx_hdr_o),
        .tx_byte_i(tx_byte_o), .tx_last_i(tx_last_o), .rx_start_o(rx_start_i), .rx_hdr_o(rx_hdr_i),
        .rx_vld_o(rx_byte_vld_i), .rx_byte_o(rx_byte_i), .rx_done_o(rx_done_i));
    always #2 clk_i = ~clk_i;
    task automatic give_verdict();
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] ix, input logic [15:0] wd);
        {cyc_i, stb_i, we_i} <= {2'b11, w};
        adr_i <= {ix, 2'b00};
        sel_i <= 4'h3;
        dat_i <= {16'h0, wd};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        r = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
        @(posedge clk_i);
    endtask
    task automatic rd_chk(input logic [3:0] ix, input logic [15:0] e);
        wb(1'b0, ix, 16'h0);
        chk("register", r, {16'h0, e});
    endtask
    task automatic tx_case(input logic [15:0] hi, lo, ctl, input logic [2:0] f,
        input logic [28:0] id, m, input int n);
        wb(1'b1, 4'h7, hi);
        wb(1'b1, 4'h6, lo);
        wb(1'b1, 4'h0, ctl);
        eng.tx_frame();
        chk("tx flags", 32'(eng.got_hdr[35:33]), 32'(f));
        chk("tx dlc", 32'(eng.got_hdr.dlc), ctl[15] ? 32'h8 : 32'(ctl[15:12]));
        chk("tx id", 32'(eng.got_hdr.id & m), 32'(id));
        chk("tx count", 32'(eng.got_n), 32'(n));
        for (int i = 0; i < n; i++)
            chk("tx byte", 32'(eng.got[i]), 32'(8'h11 * (i + 1)));
    endtask
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 9; i++)
            rd_chk(4'(i), 16'h0);
        wb(1'b1, 4'hc, 16'h5a5a);
        rd_chk(4'hc, 16'h0);
        for (int i = 0; i < 4; i++)
            wb(1'b1, 4'(5 - i), 16'(16'h1122 + 16'h2222 * i));
        tx_case({11'h5a3, 5'h07}, 16'hffff, 16'h3000, 3'b000, 29'h5a3, 29'h7ff, 3);
        tx_case({11'h5a3, 5'h17}, 16'hffff, 16'h2000, 3'b010, 29'h5a3, 29'h7ff, 0);
        tx_case({IDX[28:18], 2'b11, IDX[17:15]}, {IDX[14:0], 1'b0}, 16'hc000, 3'b101, IDX,
            29'h1fffffff, 8);
        tx_case({IDX[28:18], 2'b11, IDX[17:15]}, {IDX[14:0], 1'b1}, 16'h5000, 3'b111, IDX,
            29'h1fffffff, 0);
        eng.rx_frame('{1'b1, 1'b0, 1'b0, IDR, 4'h2}, 64'hc1c2c3c4c5c6c7c8, 4);
        rd_chk(4'h7, {IDR[28:18], 2'b01, IDR[17:15]});
        rd_chk(4'h6, {IDR[14:0], 1'b0});
        rd_chk(4'h5, 16'hc1c2);
        rd_chk(4'h4, 16'h3344);
        wb(1'b0, 4'h0, 16'h0);
        chk("length", 32'(r[15:12]), 32'h2);
        eng.rx_frame('{1'b0, 1'b1, 1'b0, 29'h3c5, 4'h0}, 64'h0, 0);
        rd_chk(4'h7, {11'h3c5, 5'h10});
        rd_chk(4'h6, {IDR[14:0], 1'b0});
        eng.rx_frame('{1'b0, 1'b0, 1'b0, 29'h2b1, 4'hc}, 64'h0102030405060708, 8);
        rd_chk(4'h7, {11'h2b1, 5'h00});
        rd_chk(4'h2, 16'h0708);
        wb(1'b0, 4'h0, 16'h0);
        chk("raw length", 32'(r[15:12]), 32'hc);
        give_verdict();
    end
endmodule // test_can_message_buffer_layout
`default_nettype wire
